// ### hdl/dual_wiper_spi_slave.sv
// Purpose: Serial mode-0 slave holding two 128-tap wiper registers and access control.
// Assumes: Serial clock stands still while select is high; writes only at select rise.
// Notes: Link logic runs on the serial clock and is held in reset by select high.
`timescale 1ns/1ps
`default_nettype none

module dual_wiper_spi_slave #(
	parameter int TAPS = dual_wiper_pkg::TAP_COUNT
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic clkEn,
	input wire logic sck,
	input wire logic csN,
	input wire logic sdi,
	output logic sdoOut,
	output logic sdoOe,
	output logic [7:0] wiper0Position,
	output logic [7:0] wiper1Position,
	output logic [TAPS-1:0] tapSelect0,
	output logic [TAPS-1:0] tapSelect1,
	output logic shutdownActive,
	output logic openDrainSel,
	output logic standby
);

	// Link domain: shift window, bit count, serial output

	logic [15:0] window_q, window_d;
	logic [3:0] bitCnt_q, bitCnt_d;
	logic full_q, full_d;
	logic sdoBit_q, sdoBit_d;
	logic [15:0] shifted;
	logic [7:0] respValue;
	logic [7:0] accessRead;

	// System domain register state
	logic [7:0] wiper0_q, wiper0_d;
	logic [7:0] wiper1_q, wiper1_d;
	logic shdnN_q, shdnN_d;
	logic odSel_q, odSel_d;
	logic frameOk_q, frameOk_d;

	// Frame-end capture, clocked by select rising
	logic [15:0] cmdWord_q;
	logic cmdValid_q;

	logic csLevel, csRise, csFall;
	dual_wiper_pkg::target_t cmdTarget;
	logic [7:0] cmdData;

	always_comb begin
		accessRead = 8'h00;
		accessRead[dual_wiper_pkg::ACR_SHUTDOWN_N_BIT_POS] = shdnN_q;
		accessRead[dual_wiper_pkg::ACR_ODSEL_POS] = odSel_q;
	end

	// Register values only change at select rise, so they are
	// steady for the whole of any frame that reads them here.
	always_comb begin
		case (dual_wiper_pkg::decodeTarget(shifted[15:8]))
			dual_wiper_pkg::TGT_WIPER0: respValue = wiper0_q;
			dual_wiper_pkg::TGT_WIPER1: respValue = wiper1_q;
			dual_wiper_pkg::TGT_ACCESS: respValue = accessRead;
			default: respValue = 8'h00;
		endcase
	end

	always_comb begin
		shifted = {window_q[14:0], sdi};
		bitCnt_d = bitCnt_q + 4'h1;
		full_d = full_q;
		window_d = shifted;
		if (bitCnt_q == 4'hF) begin
			full_d = 1'b1;
			// Two bytes in: a read swaps its response in for the echo slot
			if (dual_wiper_pkg::isReadOp(shifted[15:8])) begin
				window_d = {dual_wiper_pkg::ECHO_CODE,
					dual_wiper_pkg::echoAddr(shifted[15:8]), respValue};
			end
		end
	end

	// Select high holds the link in reset: nothing is sampled outside a frame
	always_ff @(posedge sck or posedge csN) begin
		if (csN) begin
			window_q <= 16'h0000;
			bitCnt_q <= 4'h0;
			full_q <= 1'b0;
		end else begin
			window_q <= window_d;
			bitCnt_q <= bitCnt_d;
			full_q <= full_d;
		end
	end

	always_comb begin
		sdoBit_d = window_q[15];
	end

	always_ff @(negedge sck or posedge csN) begin
		if (csN) begin
			sdoBit_q <= 1'b0;
		end else begin
			sdoBit_q <= sdoBit_d;
		end
	end

	// Open-drain only ever pulls low; the high level comes from the pull-up
	always_comb begin
		sdoOut = sdoBit_q & ~odSel_q;
		if (csN) begin
			sdoOe = 1'b0;
		end else if (odSel_q) begin
			sdoOe = ~sdoBit_q;
		end else begin
			sdoOe = 1'b1;
		end
	end

	// Snapshot at select rise; the link counters clear on the same edge,
	// so the capture sees the values of the frame that just ended.
	always_ff @(posedge csN) begin
		cmdWord_q <= window_q;
		cmdValid_q <= full_q && (bitCnt_q[2:0] == 3'h0);
	end

	// System domain

	cs_level_sync #(
		.RESET_LEVEL(1'b1)
	) u_cs_sync (
		.clk(clk),
		.rst(rst),
		.clkEn(clkEn),
		.asyncIn(csN),
		.level(csLevel),
		.rise(csRise),
		.fall(csFall)
	);

	assign cmdTarget = dual_wiper_pkg::decodeTarget(cmdWord_q[15:8]);
	assign cmdData = cmdWord_q[7:0];

	always_comb begin
		wiper0_d = wiper0_q;
		wiper1_d = wiper1_q;
		shdnN_d = shdnN_q;
		odSel_d = odSel_q;
		frameOk_d = frameOk_q;
		if (csFall) begin
			frameOk_d = 1'b1;
		end
		// Snapshot is stable long before the synchronised rise arrives
		if (csRise && frameOk_q && cmdValid_q
			&& dual_wiper_pkg::isWriteOp(cmdWord_q[15:8])) begin
			case (cmdTarget)
				dual_wiper_pkg::TGT_WIPER0: begin
					wiper0_d = cmdData;
				end
				dual_wiper_pkg::TGT_WIPER1: begin
					wiper1_d = cmdData;
				end
				dual_wiper_pkg::TGT_ACCESS: begin
					shdnN_d = cmdData[dual_wiper_pkg::ACR_SHUTDOWN_N_BIT_POS];
					odSel_d = cmdData[dual_wiper_pkg::ACR_ODSEL_POS];
				end
				default: begin
					wiper0_d = wiper0_q;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wiper0_q <= dual_wiper_pkg::RESET_WIPER;
			wiper1_q <= dual_wiper_pkg::RESET_WIPER;
			shdnN_q <= dual_wiper_pkg::RESET_ACCESS[dual_wiper_pkg::ACR_SHUTDOWN_N_BIT_POS];
			odSel_q <= dual_wiper_pkg::RESET_ACCESS[dual_wiper_pkg::ACR_ODSEL_POS];
			frameOk_q <= 1'b0;
		end else if (clkEn) begin
			wiper0_q <= wiper0_d;
			wiper1_q <= wiper1_d;
			shdnN_q <= shdnN_d;
			odSel_q <= odSel_d;
			frameOk_q <= frameOk_d;
		end
	end

	// Tap switch decode, one per channel

	logic [7:0] chanPos [2];
	logic [TAPS-1:0] tapSel_q [2];
	logic [TAPS-1:0] tapSel_d [2];

	assign chanPos[0] = wiper0_q;
	assign chanPos[1] = wiper1_q;

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_chan
			logic [7:0] clamped;
			// Codes above full scale stay on the top tap to keep order monotonic
			assign clamped = (chanPos[ch] > dual_wiper_pkg::TAP_MAX)
				? dual_wiper_pkg::TAP_MAX : chanPos[ch];

			always_comb begin
				tapSel_d[ch] = '0;
				if (shdnN_q) begin
					tapSel_d[ch][clamped[6:0]] = 1'b1;
				end
			end

			always_ff @(posedge clk) begin
				if (rst) begin
					tapSel_q[ch] <= '0;
				end else if (clkEn) begin
					tapSel_q[ch] <= tapSel_d[ch];
				end
			end
		end
	endgenerate

	assign tapSelect0 = tapSel_q[0];
	assign tapSelect1 = tapSel_q[1];
	assign wiper0Position = wiper0_q;
	assign wiper1Position = wiper1_q;
	// One bit drives both arrays open and clears every tap select on both channels
	assign shutdownActive = ~shdnN_q;
	assign openDrainSel = odSel_q;
	assign standby = csLevel;

endmodule : dual_wiper_spi_slave

`default_nettype wire

// ### hdl/dual_wiper_pkg.sv
// Purpose: Shared constants, types and instruction decoding for the dual wiper serial slave.
// Assumes: Instruction byte is opcode in bits 7..5 and register address in bits 4..0.
// Notes: Decoding helpers are used in both the link and the system clock domains.

package dual_wiper_pkg;

	localparam int REG_W = 8;
	localparam int ADDR_W = 5;
	localparam int TAP_COUNT = 128;
	localparam int WINDOW_BITS = 16;
	localparam logic [7:0] TAP_MAX = 8'h7F;

	localparam logic [4:0] ADDR_WIPER0 = 5'h00;
	localparam logic [4:0] ADDR_WIPER1 = 5'h01;
	localparam logic [4:0] ADDR_ACCESS = 5'h10;

	localparam logic [7:0] RESET_WIPER = 8'h40;
	localparam logic [7:0] RESET_ACCESS = 8'h40;
	localparam int ACR_SHUTDOWN_N_BIT_POS = 6;
	localparam int ACR_ODSEL_POS = 1;

	localparam logic [2:0] OP_NOP = 3'h0;
	localparam logic [2:0] OP_ACR_RD = 3'h1;
	localparam logic [2:0] OP_ACR_WR = 3'h3;
	localparam logic [2:0] OP_ADDR_RD = 3'h4;
	localparam logic [2:0] OP_ADDR_WR = 3'h6;
	localparam logic [2:0] ECHO_CODE = 3'h7;

	typedef enum logic [1:0] {TGT_NONE, TGT_WIPER0, TGT_WIPER1, TGT_ACCESS} target_t;

	function automatic target_t decodeTarget(input logic [7:0] instr);
		target_t t;
		t = TGT_NONE;
		case (instr[7:5])
			OP_ACR_RD, OP_ACR_WR: begin
				t = TGT_ACCESS;
			end
			OP_ADDR_RD, OP_ADDR_WR: begin
				case (instr[4:0])
					ADDR_WIPER0: t = TGT_WIPER0;
					ADDR_WIPER1: t = TGT_WIPER1;
					ADDR_ACCESS: t = TGT_ACCESS;
					default: t = TGT_NONE;
				endcase
			end
			default: t = TGT_NONE;
		endcase
		return t;
	endfunction : decodeTarget

	function automatic logic isReadOp(input logic [7:0] instr);
		return ((instr[7:5] == OP_ACR_RD) || (instr[7:5] == OP_ADDR_RD))
			&& (decodeTarget(instr) != TGT_NONE);
	endfunction : isReadOp

	function automatic logic isWriteOp(input logic [7:0] instr);
		return ((instr[7:5] == OP_ACR_WR) || (instr[7:5] == OP_ADDR_WR))
			&& (decodeTarget(instr) != TGT_NONE);
	endfunction : isWriteOp

	function automatic logic [4:0] echoAddr(input logic [7:0] instr);
		return (instr[7:5] == OP_ACR_RD) ? ADDR_ACCESS : instr[4:0];
	endfunction : echoAddr

endpackage : dual_wiper_pkg

// ### hdl/cs_level_sync.sv
// Purpose: Two-flop synchroniser for the select pin with edge pulses.
// Assumes: Input is asynchronous to clk; clkEn low freezes every stage.
// Notes: Edges are taken from the second stage and a third copy only.
`timescale 1ns/1ps
`default_nettype none

module cs_level_sync #(
	parameter logic RESET_LEVEL = 1'b1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic clkEn,
	input wire logic asyncIn,
	output logic level,
	output logic rise,
	output logic fall
);

	logic stage1_q, stage1_d;
	logic stage2_q, stage2_d;
	logic prev_q, prev_d;

	always_comb begin
		stage1_d = asyncIn;
		stage2_d = stage1_q;
		prev_d = stage2_q;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			stage1_q <= RESET_LEVEL;
			stage2_q <= RESET_LEVEL;
			prev_q <= RESET_LEVEL;
		end else if (clkEn) begin
			stage1_q <= stage1_d;
			stage2_q <= stage2_d;
			prev_q <= prev_d;
		end
	end

	assign level = stage2_q;
	assign rise = stage2_q & ~prev_q;
	assign fall = ~stage2_q & prev_q;

endmodule : cs_level_sync

`default_nettype wire

// ### bench/dual_wiper_spi_slave_checker.sv
// Purpose: Port assertions for the dual wiper serial slave.
// Assumes: clkEn high; serial output line pulled up.
// Notes: All checks sampled on the system clock.
`timescale 1ns/1ps
`default_nettype none
module dual_wiper_spi_slave_checker #(
	parameter int TAPS = 128
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic csN,
	input wire logic sdoOut,
	input wire logic sdoOe,
	input wire logic [7:0] wiper0Position,
	input wire logic [7:0] wiper1Position,
	input wire logic [TAPS-1:0] tapSelect0,
	input wire logic [TAPS-1:0] tapSelect1,
	input wire logic shutdownActive,
	input wire logic openDrainSel,
	input wire logic standby
);
	logic [TAPS-1:0] exp0;
	// Codes above 7Fh clamp to the top tap
	assign exp0 = TAPS'(1) << (wiper0Position[7] ? 8'h7F : wiper0Position);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_oe_off_idle: assert property (csN |-> !sdoOe)
		else $error("output enabled while deselected");
	a_od_never_high: assert property (openDrainSel |-> !sdoOut)
		else $error("open-drain output drives high");
	a_pp_drive_frame: assert property (!openDrainSel && !csN |-> sdoOe)
		else $error("push-pull output idle in frame");
	a_hold_in_frame: assert property (
		(!csN)[*5] |-> $stable(wiper0Position) && $stable(wiper1Position))
		else $error("register moved during frame");
	a_change_when_idle: assert property (
		!$stable(wiper0Position) || !$stable(wiper1Position) || !$stable(shutdownActive)
		|| !$stable(openDrainSel) |-> csN && $past(csN, 2))
		else $error("register changed without select rise");
	a_shutdown_n_bit_taps_off: assert property (
		shutdownActive && $past(shutdownActive) |-> tapSelect0 == '0 && tapSelect1 == '0)
		else $error("tap closed in shutdown");
	a_tap_follow: assert property (
		!shutdownActive && !$past(shutdownActive) && $stable(wiper0Position)
		&& !$past(rst) |-> tapSelect0 == exp0)
		else $error("tap select does not match wiper");
	a_reset_values: assert property (
		$fell(rst) |-> wiper0Position == 8'h40 && wiper1Position == 8'h40
		&& !shutdownActive && !openDrainSel && standby)
		else $error("wrong value after reset");
	c_shutdown: cover property (shutdownActive);
	c_od_frame: cover property (openDrainSel && !csN);
	c_commit: cover property (!$stable(wiper1Position));
endmodule : dual_wiper_spi_slave_checker
bind dual_wiper_spi_slave dual_wiper_spi_slave_checker #(.TAPS(TAPS)) i_chk (
	.clk(clk), .rst(rst), .csN(csN), .sdoOut(sdoOut), .sdoOe(sdoOe),
	.wiper0Position(wiper0Position), .wiper1Position(wiper1Position),
	.tapSelect0(tapSelect0), .tapSelect1(tapSelect1),
	.shutdownActive(shutdownActive), .openDrainSel(openDrainSel), .standby(standby));
`default_nettype wire

// ### bench/spi_host_model.sv
// Purpose: Mode-0 serial host driving clock, select and data.
// Assumes: Half period 40 ns; frames are whole bytes.
// Notes: Clock stands low between frames; 1 us gap after select rise.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	output logic sck,
	output logic csN,
	output logic sdi,
	input wire logic sdoLine
);
	initial begin
		sck = 1'b0;
		csN = 1'b1;
		sdi = 1'b0;
	end
	task automatic xfer(input logic [31:0] tx, input int nBits, output logic [31:0] rx);
		rx = '0;
		csN = 1'b0;
		for (int i = nBits - 1; i >= 0; i--) begin
			sdi = tx[i];
			#40 sck = 1'b1;
			rx = {rx[30:0], sdoLine};
			#40 sck = 1'b0;
		end
		#40 csN = 1'b1;
		// Stale data must not look valid
		sdi = ~sdi;
		#1000;
	endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// ### bench/dual_wiper_spi_slave_tb.sv
// Purpose: Self-checking bench for the dual wiper serial slave.
// Assumes: Pull-up on the serial output line.
// Notes: Shadow registers predict every write and read.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
	$display("FAIL %s exp %h got %h", nm, e, g); end end
module dual_wiper_spi_slave_tb;
	logic clk, rst, clkEn, sck, csN, sdi, sdoOut, sdoOe, shutdownActive, openDrainSel, standby;
	logic [7:0] wiper0Position, wiper1Position, w0, w1, access_control;
	logic [127:0] tapSelect0, tapSelect1;
	logic [31:0] rx;
	int mismatches = 0;
	int compares = 0;
	logic [7:0] rds [4] = '{8'h80, 8'h81, 8'h90, 8'h3F};
	logic [15:0] cn [12] = '{16'h6000, 16'h60FF, 16'hC07F, 16'hC180, 16'hD000, 16'hE155,
		16'hC233, 16'h1F12, 16'h4012, 16'hA112, 16'h6040, 16'hC000};
	wire logic sdoLine = sdoOe ? sdoOut : 1'b1;
	dual_wiper_spi_slave i_dut (.clk(clk), .rst(rst), .clkEn(clkEn), .sck(sck), .csN(csN),
		.sdi(sdi), .sdoOut(sdoOut), .sdoOe(sdoOe), .wiper0Position(wiper0Position),
		.wiper1Position(wiper1Position), .tapSelect0(tapSelect0), .tapSelect1(tapSelect1),
		.shutdownActive(shutdownActive), .openDrainSel(openDrainSel), .standby(standby));
	spi_host_model i_host (.sck(sck), .csN(csN), .sdi(sdi), .sdoLine(sdoLine));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	function automatic logic [127:0] tapOf(input logic [7:0] w, input logic sd);
		return sd ? '0 : (128'h1 << (w[7] ? 8'h7F : w));
	endfunction : tapOf
	function automatic logic [7:0] regOf(input logic [4:0] a);
		return (a == 5'h00) ? w0 : (a == 5'h01) ? w1 : access_control;
	endfunction : regOf
	task automatic rd(input logic [7:0] ins);
		logic [7:0] dmy;
		logic [4:0] a;
		dmy = 8'($urandom);
		a = (ins[7:5] == 3'h1) ? 5'h10 : ins[4:0];
		i_host.xfer({ins, dmy, 8'h00, ~dmy}, 32, rx);
		// Link is held clear while select is high, so the pass-through delay shows zeros here
		`CHK("thru", 8'h00, rx[23:16])
		`CHK("echo", {3'h7, a}, rx[15:8])
		`CHK("data", regOf(a), rx[7:0])
	endtask : rd
	task automatic check;
		`CHK("wiper0", w0, wiper0Position)
		`CHK("wiper1", w1, wiper1Position)
		`CHK("shutdown_n_bit", ~access_control[6], shutdownActive)
		`CHK("odsel", access_control[1], openDrainSel)
		`CHK("tap0", tapOf(w0, ~access_control[6]), tapSelect0)
		`CHK("tap1", tapOf(w1, ~access_control[6]), tapSelect1)
		`CHK("standby", 1'b1, standby)
		for (int k = 0; k < 4; k++) rd(rds[k]);
	endtask : check
	task automatic wr(input logic [7:0] ins, input logic [7:0] d);
		logic [4:0] a;
		a = (ins[7:5] == 3'h3) ? 5'h10 : ins[4:0];
		i_host.xfer({16'h0, ins, d}, 16, rx);
		if (ins[7:5] == 3'h3 || ins[7:5] == 3'h6) begin
			if (a == 5'h00) w0 = d;
			else if (a == 5'h01) w1 = d;
			else if (a == 5'h10) access_control = d & 8'h42;
		end
		check();
	endtask : wr
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : wrap_up
	initial begin
		// Whole run is about 24 writes of 17 us each
		#2000000;
		mismatches++;
		wrap_up();
	end
	initial begin
		rst = 1'b1;
		clkEn = 1'b1;
		w0 = 8'h40;
		w1 = 8'h40;
		access_control = 8'h40;
		void'($urandom(91));
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (5) @(posedge clk);
		check();
		$display("test reset done");
		foreach (cn[i]) wr(cn[i][15:8], cn[i][7:0]);
		$display("test corners done");
		clkEn <= 1'b0;
		repeat (3) @(posedge clk);
		`CHK("frozen", w0, wiper0Position)
		clkEn <= 1'b1;
		repeat (2) @(posedge clk);
		check();
		$display("test freeze done");
		for (int n = 0; n < 12; n++)
			wr({3'($urandom), ($urandom % 2) ? 5'($urandom % 2) : 5'($urandom)}, 8'($urandom));
		$display("test random done");
		wrap_up();
	end
endmodule : dual_wiper_spi_slave_tb
`default_nettype wire
